// ### hdl/debug_link_cfg.svh
// Encodings, field positions and reset values of the debug link engine
`ifndef DEBUG_LINK_CFG_SVH
`define DEBUG_LINK_CFG_SVH
`define OPC_HI 7
`define OPC_LO 5
`define OP_DIRECT_READ 3'h0
`define OP_INDIRECT_READ 3'h1
`define OP_DIRECT_WRITE 3'h2
`define OP_INDIRECT_WRITE 3'h3
`define OP_CONTROL_REG_READ 3'h4
`define OP_LOOP_COUNT 3'h5
`define OP_CONTROL_REG_WRITE 3'h6
`define OP_KEY 3'h7
`define PMODE_HI 3
`define PMODE_LO 2
`define SZA_HI 1
`define SZA_LO 0
`define SZB_HI 1
`define SZB_LO 0
`define SZC_HI 1
`define SZC_LO 0
`define CSA_HI 3
`define CSA_LO 0
`define KEY_INFO_BIT 2
`define PM_PLAIN 2'h0
`define PM_INC 2'h1
`define PM_PTR 2'h2
`define SZC_64 2'h0
`define SZC_128 2'h1
`define KEY_BYTES 5'h08
`define INFO_BYTES_LONG 5'h10
`define ACK_CHAR 8'h40
`define RST_PTR 32'h0000_0000
`define RST_LOOP 8'h00
`define RST_DATA 32'h0000_0000
`endif

// ### hdl/debug_link_pkg.sv
// Types shared by the debug link engine and its surroundings
package debug_link_pkg;
  typedef enum logic [3:0] {
    stIdle  = 4'h0,
    stAddr  = 4'h1,
    stWData = 4'h2,
    stWBus  = 4'h3,
    stAck   = 4'h4,
    stRBus  = 4'h5,
    stPtrRd = 4'h6,
    stCsRd  = 4'h7,
    stCsWr  = 4'h8,
    stLoop  = 4'h9,
    stKeyRx = 4'hA,
    stInfoTx = 4'hB
  } state_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } busReq_t;
  typedef struct packed {
    logic       we;
    logic [3:0] addr;
    logic [7:0] wdata;
  } csReq_t;
endpackage : debug_link_pkg

// ### hdl/debug_link_instruction_engine.sv
// Instruction engine of the single-wire debug link, with its response FIFO
`include "debug_link_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module response_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wrPtr_reg;
  logic [AW:0]      rdPtr_reg;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign inReady  = (wrPtr_reg[AW-1:0] != rdPtr_reg[AW-1:0]) || (wrPtr_reg[AW] == rdPtr_reg[AW]);
  assign outValid = wrPtr_reg != rdPtr_reg;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem_reg[rdPtr_reg[AW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else if (flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule : response_fifo

module debug_link_instruction_engine #(
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned GUARD_W    = 8
) (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  rxValid,
  input  wire logic [7:0]            rxByte,
  input  wire logic                  rxSync,
  input  wire logic                  rxBreak,
  input  wire logic                  bitTick,
  input  wire logic [GUARD_W-1:0]    turnaroundBits,
  output logic                       txValid,
  input  wire logic                  txReady,
  output logic [7:0]                 txByte,
  output debug_link_pkg::busReq_t    busOut,
  input  wire logic                  busAck,
  input  wire logic [7:0]            busRdata,
  output debug_link_pkg::csReq_t     csOut,
  input  wire logic [7:0]            csRdata,
  output logic                       keyValid,
  output logic [7:0]                 keyByte,
  input  wire logic [127:0]          infoBlock,
  output logic                       syncEvent,
  output logic                       busy
);
  import debug_link_pkg::*;

  state_t             state_reg;
  logic [7:0]         cmd_reg;
  logic [4:0]         cnt_reg;
  logic [4:0]         len_reg;
  logic [31:0]        data_reg;
  logic [31:0]        ptr_reg;
  logic [7:0]         loop_reg;
  logic               expectCmd_reg;
  logic               guardPending_reg;
  logic [GUARD_W-1:0] guardCnt_reg;
  logic               keyValid_reg;
  logic [7:0]         keyByte_reg;
  logic               syncEvent_reg;
  csReq_t             csReq_reg;
  logic               pushValid;
  logic               pushReady;
  logic [7:0]         pushData;
  logic               pushFire;
  logic               popValid;
  logic               step;
  logic               lastByte;
  logic               done;
  logic               finish;
  logic               cmdTake;
  logic [31:0]        dataNext;
  logic               ptrInc;

  function automatic logic [4:0] sizeBytes(input logic [1:0] f);
    sizeBytes = {3'h0, f} + 5'h01;
  endfunction : sizeBytes

  function automatic logic [7:0] getByte(input logic [127:0] w, input logic [4:0] i);
    getByte = w[{i[3:0], 3'h0} +: 8];
  endfunction : getByte

  function automatic logic [31:0] putByte(input logic [31:0] w, input logic [1:0] i, input logic [7:0] b);
    logic [31:0] r;
    r = w;
    r[{i, 3'h0} +: 8] = b;
    putByte = r;
  endfunction : putByte

  // Command fields sit at fixed positions in the command byte
  function automatic logic [4:0] lenOf(input logic [7:0] c);
    case (c[`OPC_HI:`OPC_LO])
      `OP_INDIRECT_WRITE: lenOf = (c[`PMODE_HI:`PMODE_LO] == `PM_PTR) ?
                                  sizeBytes(c[`SZA_HI:`SZA_LO]) : sizeBytes(c[`SZB_HI:`SZB_LO]);
      `OP_INDIRECT_READ:  lenOf = sizeBytes(c[`SZB_HI:`SZB_LO]);
      `OP_LOOP_COUNT:     lenOf = sizeBytes(c[`SZB_HI:`SZB_LO]);
      `OP_KEY:            lenOf = (c[`KEY_INFO_BIT] && c[`SZC_HI:`SZC_LO] == `SZC_128) ?
                                  `INFO_BYTES_LONG : `KEY_BYTES;
      default:            lenOf = 5'h01;
    endcase
  endfunction : lenOf

  // Direct-addressed access is not handled here and leaves the engine idle
  function automatic state_t startOf(input logic [7:0] c);
    case (c[`OPC_HI:`OPC_LO])
      `OP_INDIRECT_WRITE:    startOf = (c[`PMODE_HI:`PMODE_LO] == `PM_PTR) ? stAddr : stWData;
      `OP_INDIRECT_READ:     startOf = (c[`PMODE_HI:`PMODE_LO] == `PM_PTR) ? stPtrRd : stRBus;
      `OP_CONTROL_REG_READ:  startOf = stCsRd;
      `OP_CONTROL_REG_WRITE: startOf = stCsWr;
      `OP_LOOP_COUNT:        startOf = stLoop;
      `OP_KEY: begin
        if (c[`KEY_INFO_BIT]) begin
          startOf = stInfoTx;
        end else if (c[`SZC_HI:`SZC_LO] == `SZC_64) begin
          startOf = stKeyRx;
        end else begin
          startOf = stIdle;
        end
      end
      default:               startOf = stIdle;
    endcase
  endfunction : startOf

  // A command byte is taken only right after a sync character
  assign cmdTake  = (state_reg == stIdle) && expectCmd_reg && rxValid;
  assign lastByte = (cnt_reg + 5'h01) == len_reg;
  assign pushFire = pushValid && pushReady;
  assign busy     = state_reg != stIdle;
  assign dataNext = putByte((cnt_reg == 5'h00) ? `RST_DATA : data_reg, cnt_reg[1:0], rxByte);

  always_comb begin
    step = 1'b0;
    case (state_reg)
      stAddr, stWData, stCsWr, stLoop, stKeyRx: step = rxValid;
      stWBus:                                   step = busAck;
      stAck, stRBus, stPtrRd, stCsRd, stInfoTx: step = pushFire;
      default:                                  step = 1'b0;
    endcase
  end

  assign done   = step && (lastByte || state_reg == stAck);
  assign finish = done && state_reg != stAddr && state_reg != stWData &&
                  state_reg != stWBus && state_reg != stLoop;

  // Post-increment moves the pointer by the payload width once the access ends
  assign ptrInc = done && (state_reg == stWBus || state_reg == stRBus) &&
                  cmd_reg[`PMODE_HI:`PMODE_LO] == `PM_INC;

  always_comb begin
    pushValid = 1'b0;
    pushData  = `ACK_CHAR;
    case (state_reg)
      stAck: begin
        pushValid = 1'b1;
      end
      stRBus: begin
        pushValid = busAck;
        pushData  = busRdata;
      end
      stPtrRd: begin
        pushValid = 1'b1;
        pushData  = getByte({96'h0, ptr_reg}, cnt_reg);
      end
      stCsRd: begin
        pushValid = 1'b1;
        pushData  = csRdata;
      end
      stInfoTx: begin
        pushValid = 1'b1;
        pushData  = getByte(infoBlock, cnt_reg);
      end
      default: begin
        pushValid = 1'b0;
      end
    endcase
  end

  // Reads are only issued while the FIFO has room, so read data is never dropped
  always_comb begin
    busOut.req   = (state_reg == stWBus) || (state_reg == stRBus && pushReady);
    busOut.we    = state_reg == stWBus;
    busOut.addr  = ptr_reg + 32'(cnt_reg);
    busOut.wdata = getByte({96'h0, data_reg}, cnt_reg);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= stIdle;
      cmd_reg   <= 8'h00;
      cnt_reg   <= 5'h00;
      len_reg   <= 5'h01;
    end else if (rxBreak) begin
      state_reg <= stIdle;
      cnt_reg   <= 5'h00;
    end else if (cmdTake) begin
      cmd_reg   <= rxByte;
      state_reg <= startOf(rxByte);
      len_reg   <= lenOf(rxByte);
      cnt_reg   <= 5'h00;
    end else if (done) begin
      cnt_reg <= 5'h00;
      case (state_reg)
        stAddr:  state_reg <= stAck;
        stWData: state_reg <= stWBus;
        stWBus:  state_reg <= stAck;
        stLoop:  state_reg <= stIdle;
        default: begin
          // Later iterations restart without sync or command byte
          if (loop_reg != `RST_LOOP) begin
            state_reg <= startOf(cmd_reg);
          end else begin
            state_reg <= stIdle;
          end
        end
      endcase
    end else if (step) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      data_reg <= `RST_DATA;
    end else if ((state_reg == stAddr || state_reg == stWData) && rxValid) begin
      data_reg <= dataNext;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ptr_reg <= `RST_PTR;
    end else if (state_reg == stAddr && rxValid && lastByte) begin
      ptr_reg <= dataNext;
    end else if (ptrInc) begin
      ptr_reg <= ptr_reg + 32'(len_reg);
    end
  end

  // Counts above 255 are not supported, so only the low operand byte is kept
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      loop_reg <= `RST_LOOP;
    end else if (rxBreak) begin
      loop_reg <= `RST_LOOP;
    end else if (state_reg == stLoop && rxValid && cnt_reg == 5'h00) begin
      loop_reg <= rxByte;
    end else if (finish && loop_reg != `RST_LOOP) begin
      loop_reg <= loop_reg - 8'h01;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      expectCmd_reg <= 1'b0;
    end else if (rxBreak || cmdTake) begin
      expectCmd_reg <= 1'b0;
    end else if (rxSync) begin
      expectCmd_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      syncEvent_reg <= 1'b0;
      keyValid_reg  <= 1'b0;
      keyByte_reg   <= 8'h00;
      csReq_reg     <= '0;
    end else begin
      syncEvent_reg <= rxSync;
      keyValid_reg  <= (state_reg == stKeyRx) && rxValid && !rxBreak;
      if (state_reg == stKeyRx && rxValid) begin
        keyByte_reg <= rxByte;
      end
      csReq_reg.we <= (state_reg == stCsWr) && rxValid && !rxBreak;
      if (cmdTake) begin
        csReq_reg.addr <= rxByte[`CSA_HI:`CSA_LO];
      end
      if (state_reg == stCsWr && rxValid) begin
        csReq_reg.wdata <= rxByte;
      end
    end
  end

  // Any received byte is a direction change, so the next answer waits again
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      guardPending_reg <= 1'b0;
      guardCnt_reg     <= '0;
    end else if (rxValid || rxBreak) begin
      guardPending_reg <= 1'b1;
      guardCnt_reg     <= '0;
    end else if (guardPending_reg && popValid) begin
      if (guardCnt_reg >= turnaroundBits) begin
        guardPending_reg <= 1'b0;
      end else if (bitTick) begin
        guardCnt_reg <= guardCnt_reg + 1'b1;
      end
    end
  end

  assign txValid   = popValid && !guardPending_reg;
  assign keyValid  = keyValid_reg;
  assign keyByte   = keyByte_reg;
  assign syncEvent = syncEvent_reg;
  always_comb begin
    csOut      = csReq_reg;
    csOut.addr = cmd_reg[`CSA_HI:`CSA_LO];
  end

  // Back-pressure from the line stalls reads and acknowledges through pushReady
  response_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) txFifo (
    .clock    (clock),
    .resetn   (resetn),
    .flush    (rxBreak),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushData),
    .outValid (popValid),
    .outReady (txReady && !guardPending_reg),
    .outData  (txByte)
  );
endmodule : debug_link_instruction_engine
`default_nettype wire

// ### sim/debug_host_model.sv
// Behavioural debugger at the far end of the debug link
`timescale 1ns/1ps
`default_nettype none
module debug_host_model #(
  parameter int BIT = 2
) (
  input  wire logic       clock,
  output logic            rxValid,
  output logic [7:0]      rxByte,
  output logic            rxSync,
  output logic            rxBreak,
  output logic            bitTick,
  input  wire logic       txValid,
  output logic            txReady,
  input  wire logic [7:0] txByte
);
  logic [7:0] got [$];
  logic       hold = 1'b0;
  int         seed = 32'h3782;
  int         tk   = 0;
  initial begin
    {rxValid, rxSync, rxBreak, bitTick, txReady} = 5'h00;
    rxByte = 8'h00;
  end
  // Line rate stays fixed for the whole run
  always @(posedge clock) begin
    #1;
    tk = (tk + 1) % BIT;
    bitTick = (tk == 0);
    txReady = !hold && ($random(seed) & 3) != 0;
  end
  always @(posedge clock) if (txValid && txReady) got.push_back(txByte);
  // Kind: 1 data byte, 2 sync, 4 break; the line shows the inverse once the strobe is gone
  task automatic frame(input logic [2:0] kind, input logic [7:0] b);
    @(posedge clock);
    #1;
    {rxBreak, rxSync, rxValid} = kind;
    rxByte = b;
    @(posedge clock);
    #1;
    {rxBreak, rxSync, rxValid} = 3'h0;
    rxByte = ~b;
    repeat (10 * BIT) @(posedge clock);
  endtask : frame
endmodule : debug_host_model
`default_nettype wire

// ### sim/debug_link_asserts.sv
// Port-level checker of the debug link instruction engine
`timescale 1ns/1ps
`default_nettype none
module debug_link_asserts
  import debug_link_pkg::*;
#(
  parameter int unsigned GUARD_W = 8
) (
  input wire logic                clock,
  input wire logic                resetn,
  input wire logic                rxValid,
  input wire logic [7:0]          rxByte,
  input wire logic                rxSync,
  input wire logic                rxBreak,
  input wire logic                bitTick,
  input wire logic [GUARD_W-1:0]  turnaroundBits,
  input wire logic                txValid,
  input wire logic                txReady,
  input wire logic [7:0]          txByte,
  input wire debug_link_pkg::busReq_t busOut,
  input wire logic                busAck,
  input wire debug_link_pkg::csReq_t  csOut,
  input wire logic                keyValid,
  input wire logic [7:0]          keyByte,
  input wire logic                syncEvent,
  input wire logic                busy
);
  // Bit times since the last received byte, saturating
  logic [8:0] tickCnt;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) tickCnt <= 9'h000;
    else if (rxValid) tickCnt <= {8'h00, bitTick};
    else if (bitTick && !tickCnt[8]) tickCnt <= tickCnt + 9'h001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_sync_event_pulse: assert property (rxSync |=> syncEvent)
    else $error("sync event missing");
  a_event_has_cause: assert property (syncEvent |-> $past(rxSync))
    else $error("sync event without sync");
  a_guard_time_kept: assert property ($rose(txValid) |-> tickCnt >= 9'(turnaroundBits))
    else $error("answer before turnaround");
  a_tx_byte_holds: assert property (txValid && !txReady && !rxBreak |=> txValid && $stable(txByte))
    else $error("tx byte changed while stalled");
  a_write_req_holds: assert property (busOut.req && busOut.we && !busAck && !rxBreak
    |=> busOut.req && $stable(busOut.addr) && $stable(busOut.wdata))
    else $error("bus write dropped before ack");
  a_cs_write_byte: assert property (csOut.we |-> $past(rxValid) && csOut.wdata == $past(rxByte))
    else $error("control write data mismatch");
  a_key_byte_out: assert property (keyValid |-> $past(rxValid) && keyByte == $past(rxByte))
    else $error("key byte mismatch");
  a_break_aborts: assert property (rxBreak |=> !busy && !busOut.req)
    else $error("break did not abort");
  a_idle_no_bus: assert property (!busy |-> !busOut.req)
    else $error("bus request while idle");
  c_tx_taken: cover property (txValid && txReady);
  c_bus_read: cover property (busAck && !busOut.we);
  c_cs_write: cover property (csOut.we);
  c_key_byte: cover property (keyValid);
endmodule : debug_link_asserts
`default_nettype wire
bind debug_link_instruction_engine debug_link_asserts #(.GUARD_W(GUARD_W)) chk_u (
  .clock(clock), .resetn(resetn), .rxValid(rxValid), .rxByte(rxByte), .rxSync(rxSync), .rxBreak(rxBreak),
  .bitTick(bitTick), .turnaroundBits(turnaroundBits), .txValid(txValid), .txReady(txReady), .txByte(txByte),
  .busOut(busOut), .busAck(busAck), .csOut(csOut), .keyValid(keyValid), .keyByte(keyByte),
  .syncEvent(syncEvent), .busy(busy));

// ### sim/tb.sv
// Self-checking bench of the debug link instruction engine
`include "debug_link_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import debug_link_pkg::*;
  logic         clock = 1'b0;
  logic         resetn = 1'b0;
  logic         rxValid, rxSync, rxBreak, bitTick, txValid, txReady, keyValid, syncEvent, busy;
  logic         busAck = 1'b0;
  logic [7:0]   rxByte, txByte, csRdata, keyByte;
  logic [7:0]   busRdata = 8'h00;
  logic [7:0]   turnaroundBits = 8'h00;
  logic [127:0] infoBlock;
  busReq_t      busOut;
  csReq_t       csOut;
  logic [7:0]   sysMem [logic [31:0]];
  logic [7:0]   refMem [logic [31:0]];
  logic [7:0]   exp [$];
  logic [7:0]   keyQ [$];
  logic [11:0]  csLog;
  logic [31:0]  ptr;
  int           seed = 32'h3782;
  int           err_count = 0;
  int           n_compared = 0;
  int           cyc = 0;
  debug_link_instruction_engine #(.FIFO_DEPTH(16), .GUARD_W(8)) dut_u (
    .clock(clock), .resetn(resetn), .rxValid(rxValid), .rxByte(rxByte), .rxSync(rxSync), .rxBreak(rxBreak),
    .bitTick(bitTick), .turnaroundBits(turnaroundBits), .txValid(txValid), .txReady(txReady), .txByte(txByte),
    .busOut(busOut), .busAck(busAck), .busRdata(busRdata), .csOut(csOut), .csRdata(csRdata),
    .keyValid(keyValid), .keyByte(keyByte), .infoBlock(infoBlock), .syncEvent(syncEvent), .busy(busy));
  debug_host_model dbg_u (
    .clock(clock), .rxValid(rxValid), .rxByte(rxByte), .rxSync(rxSync), .rxBreak(rxBreak),
    .bitTick(bitTick), .txValid(txValid), .txReady(txReady), .txByte(txByte));
  initial forever #2.5 clock = ~clock;
  assign csRdata = 8'hA5 ^ {4'h0, csOut.addr};
  // System bus with random wait states
  always @(posedge clock) begin
    if (busAck && busOut.we) sysMem[busOut.addr] = busOut.wdata;
    if (csOut.we) csLog = {csOut.addr, csOut.wdata};
    if (keyValid) keyQ.push_back(keyByte);
    #1;
    busAck = busOut.req && !busAck && $random(seed) % 2 == 0;
    busRdata = sysMem.exists(busOut.addr) ? sysMem[busOut.addr] : 8'h00;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end
  function automatic logic [7:0] rf(input logic [31:0] a);
    return refMem.exists(a) ? refMem[a] : 8'h00;
  endfunction : rf
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] c);
    // Change the guard count off the sampling edge like every other input
    @(posedge clock);
    #1;
    turnaroundBits = 8'($random(seed) & 3);
    dbg_u.frame(3'h2, 8'h00);
    dbg_u.frame(3'h1, c);
  endtask : cmd
  // Waits for the expected answer, then lets stray bytes show up before comparing
  task automatic drain(input string nm);
    int w;
    w = 0;
    while (dbg_u.got.size() < exp.size() && w < 3000) begin
      @(posedge clock);
      w++;
    end
    repeat (60) @(posedge clock);
    chk({nm, " count"}, dbg_u.got.size(), exp.size());
    while (exp.size() && dbg_u.got.size()) chk(nm, dbg_u.got.pop_front(), exp.pop_front());
    exp.delete();
    dbg_u.got.delete();
    $display("test %s done", nm);
  endtask : drain
  task automatic loop(input logic [7:0] n);
    cmd(8'hA0);
    dbg_u.frame(3'h1, n);
  endtask : loop
  task automatic setPtr(input logic [31:0] a);
    cmd(8'h6B);
    for (int i = 0; i < 4; i++) dbg_u.frame(3'h1, a[8*i +: 8]);
    exp.push_back(`ACK_CHAR);
    drain("pointer load");
    ptr = a;
  endtask : setPtr
  task automatic wr(input int n, input logic inc);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      refMem[ptr + i] = d;
      dbg_u.frame(3'h1, d);
    end
    exp.push_back(`ACK_CHAR);
    drain("write");
    if (inc) ptr = ptr + n;
  endtask : wr
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    infoBlock = {$random(seed), $random(seed), $random(seed), $random(seed)};
    repeat (5) @(posedge clock);
    #1;
    resetn = 1'b1;
    setPtr(32'h1234_5678);
    cmd(8'h2B);
    for (int i = 0; i < 4; i++) exp.push_back(ptr[8*i +: 8]);
    drain("pointer read");
    cmd(8'h65);
    wr(2, 1'b1);
    loop(8'h03);
    cmd(8'h64);
    for (int i = 0; i < 4; i++) wr(1, 1'b1);
    // Stalled debugger lets the response buffer fill up
    setPtr(32'h1234_5678);
    dbg_u.hold = 1'b1;
    loop(8'h13);
    cmd(8'h24);
    for (int i = 0; i < 20; i++) exp.push_back(rf(ptr + i));
    repeat (400) @(posedge clock);
    chk("read request while full", busOut.req, 1'b0);
    dbg_u.hold = 1'b0;
    drain("stream read");
    setPtr(32'h0000_0100);
    loop(8'h01);
    cmd(8'h60);
    wr(1, 1'b0);
    wr(1, 1'b0);
    setPtr(32'h0000_0100);
    loop(8'h01);
    cmd(8'h21);
    for (int i = 0; i < 4; i++) exp.push_back(rf(ptr + i % 2));
    drain("same address");
    for (int a = 0; a < 16; a += 15) begin
      cmd(8'hC0 | 8'(a));
      dbg_u.frame(3'h1, 8'h3C ^ 8'(a));
      drain("control write");
      chk("control write", csLog, {4'(a), 8'h3C ^ 8'(a)});
      cmd(8'h80 | 8'(a));
      exp.push_back(8'hA5 ^ 8'(a));
      drain("control read");
    end
    cmd(8'hE0);
    for (int i = 0; i < 8; i++) dbg_u.frame(3'h1, 8'(8'h10 + i));
    drain("key");
    chk("key count", keyQ.size(), 8);
    foreach (keyQ[i]) chk("key byte", keyQ[i], 8'h10 + i);
    for (int k = 0; k < 2; k++) begin
      cmd(8'hE4 | 8'(k));
      for (int i = 0; i < 8 + 8 * k; i++) exp.push_back(infoBlock[8*i +: 8]);
      drain("info block");
    end
    loop(8'h05);
    cmd(8'h64);
    wr(1, 1'b1);
    dbg_u.frame(3'h4, 8'h00);
    chk("busy after break", busy, 1'b0);
    dbg_u.frame(3'h1, 8'h24);
    drain("break");
    chk("busy after stray byte", busy, 1'b0);
    summarize();
  end
endmodule : tb
`default_nettype wire
